// File: shared/feedback_sync_regs.vh
`ifndef FEEDBACK_SYNC_REGS_VH
`define FEEDBACK_SYNC_REGS_VH
// channel count and feedback message width
`define NCH            4
`define FB_W           16
// register byte offsets
`define CTRL_OFS       6'h00
`define FBCFG_OFS      6'h04
`define STATUS_OFS     6'h08
`define FBVAL_OFS      6'h0c
`define UREG_OFS       6'h10
`define UREG_LAST      6'h1c
// control register fields
`define CTRL_SRC_EXT   0
`define CTRL_TRIG_SYNC 1
`define CTRL_FB_INT    2
`define CTRL_CHEN_LSB  4
`define CTRL_RST       32'h0000_0000
// feedback config word layout (instruction argument and register view)
`define CFG_IDX_LSB    0
`define CFG_SIZE_LSB   4
`define CFG_SET_BIT    9
`define CFG_OFS_LSB    16
`define CFG_RST        32'h0000_0000
// status register fields
`define ST_READY_LSB   0
`define ST_START_LSB   8
`define ST_EXT_RDY     16
`define ST_TRIG_SEEN   17
`define ST_BUSY        18
// sequencer operation codes
`define OP_FB_CFG      3'h1
`define OP_WAIT_TRIG   3'h2
`define OP_READ_FB     3'h3
`define OP_PLAY        3'h4
`define OP_UREG        3'h5
// trigger age counter width
`define AGE_W          16
`endif

// File: logic/feedback_and_start_sync.v
// Operation
// - feedback from link or internal path, branchable
// - configured: trim to index/size, add offset
// - unconfigured: untrimmed message, zero offset
// - raw select delivers message unprocessed
// - table play uses processed value as index
// - sample feedback programmed cycles after trigger
// - read feedback returns value into variable
// - user register write stores variable value
// - per-channel sync enable joins check
// - check after prefetch, before first instruction
// - prefetch loads program, table, waveform data
// - participants report ready, stall until all
// - external source reports combined ready upstream
// - internal source: local participants only
// - trigger unit joins check when enabled
// - same trigger count and holdoff per check
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "feedback_sync_regs.vh"
module feedback_and_start_sync (
  input  wire               core_clk,       // sequencer clock
  input  wire               rst,            // async reset, active high
  input  wire               ce,             // clock enable, freezes all
  input  wire [5:0]         address,        // avalon byte address
  input  wire               read,           // avalon read
  input  wire               write,          // avalon write
  input  wire [31:0]        writedata,      // avalon write data
  input  wire [3:0]         byteenable,     // avalon byte lanes
  output reg  [31:0]        readdata,       // avalon read data
  output reg                waitrequest,    // avalon stall
  input  wire               instr_valid,    // sequencer op offered
  input  wire [2:0]         instr_op,       // op code
  input  wire               instr_raw,      // raw_feedback_select
  input  wire [31:0]        instr_arg,      // delay, config or reg index
  input  wire [31:0]        instr_var,      // variable value for writes
  output reg                instr_ready_q,  // op taken
  output reg                result_valid_q, // read_feedback result pulse
  output reg  [31:0]        result_q,       // feedback value to variable
  output reg                table_play_q,   // table entry play pulse
  output reg  [`FB_W-1:0]   table_index_q,  // table entry index
  input  wire               link_trig,      // link trigger pin
  input  wire [`FB_W-1:0]   link_data,      // link feedback pins
  input  wire [`FB_W-1:0]   int_fb_data,    // internal feedback
  input  wire [`NCH-1:0]    run_req,        // channel run request level
  input  wire [`NCH-1:0]    pf_done,        // prefetch complete
  output reg  [`NCH-1:0]    pf_req_q,       // prefetch request
  output reg  [`NCH-1:0]    core_ready_q,   // core waits at barrier
  output reg  [`NCH-1:0]    start_q,        // core executes program
  input  wire               trig_ready,     // trigger unit at barrier
  output reg                trig_rearm_q,   // trigger unit restart pulse
  input  wire               ext_release,    // controller release pin
  output reg                ext_ready_q     // ready to controller pin
);
  // channel states
  localparam [1:0] CH_IDLE = 2'd0;
  localparam [1:0] CH_PF   = 2'd1;
  localparam [1:0] CH_SYNC = 2'd2;
  localparam [1:0] CH_RUN  = 2'd3;

  reg  [31:0]        ctrl_q;       // control register
  reg  [31:0]        cfg_q;        // feedback processing config
  reg  [31:0]        fbval_q;      // last sampled value
  reg  [31:0]        ureg_q [0:3]; // user registers
  reg  [1:0]         trig_s_q;     // trigger synchroniser
  reg                trig_d_q;     // trigger edge history
  reg  [`FB_W-1:0]   ld_s1_q;      // link data first stage
  reg  [`FB_W-1:0]   ld_s2_q;      // link data second stage
  reg  [1:0]         rel_s_q;      // release synchroniser
  reg  [`AGE_W-1:0]  age_q;        // cycles since trigger
  reg                seen_q;       // a trigger has arrived
  reg                pend_q;       // feedback sample pending
  reg                pend_play_q;  // pending op is table play
  reg                pend_raw_q;   // pending op uses raw select
  reg                wait_trig_q;  // stalled on trigger
  reg  [`AGE_W-1:0]  dly_q;        // programmed sample delay
  reg  [31:0]        rd_mux;       // read data mux
  reg  [`FB_W-1:0]   proc_val;     // processed feedback
  integer            i;            // user register reset index

  wire               src_ext  = ctrl_q[`CTRL_SRC_EXT];
  wire               trig_en  = ctrl_q[`CTRL_TRIG_SYNC];
  wire               fb_int   = ctrl_q[`CTRL_FB_INT];
  wire [`NCH-1:0]    chen     = ctrl_q[`CTRL_CHEN_LSB +: `NCH];
  wire               trig_edge = trig_s_q[1] & ~trig_d_q;
  wire               bus_req  = read | write;
  wire               bus_hit  = bus_req & ~waitrequest;
  wire [1:0]         ur_idx   = address[3:2];
  wire               is_ureg  = (address >= `UREG_OFS) && (address <= `UREG_LAST);
  wire               take     = instr_valid & instr_ready_q;
  // feedback message from the selected path
  wire [`FB_W-1:0]   fb_msg   = fb_int ? int_fb_data : ld_s2_q;
  wire               cfg_set  = cfg_q[`CFG_SET_BIT];
  wire [3:0]         cfg_idx  = cfg_q[`CFG_IDX_LSB +: 4];
  wire [4:0]         cfg_size = cfg_q[`CFG_SIZE_LSB +: 5];
  wire [`FB_W-1:0]   cfg_ofs  = cfg_q[`CFG_OFS_LSB +: `FB_W];
  // sample point reached once the programmed delay has elapsed
  wire               due      = pend_q & seen_q & (age_q >= dly_q);
  // size 16 shifts every one out, so the mask covers the whole message
  wire [`FB_W-1:0]   mask     = ~({`FB_W{1'b1}} << cfg_size);
  // bytes a register write may touch
  wire [31:0]        lane_m   = {{8{byteenable[3]}}, {8{byteenable[2]}},
                                 {8{byteenable[1]}}, {8{byteenable[0]}}};
  // barrier: every enabled core and trigger unit ready, plus upstream
  wire all_local = &(core_ready_q | ~chen) & (trig_ready | ~trig_en);
  wire any_wait  = |(core_ready_q & chen);
  // internal source ignores the controller entirely
  wire release_now = any_wait & all_local & (~src_ext | rel_s_q[1]);
  wire [`FB_W-1:0]   fb_pick  = pend_raw_q ? fb_msg : proc_val;
  // trim and offset; an unissued config keeps the whole message, offset 0
  always @*
  begin
    if (cfg_set)
      proc_val = ((fb_msg >> cfg_idx) & mask) + cfg_ofs;
    else
      proc_val = fb_msg;
  end
  // register read mux; unmapped reads return zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (address == `CTRL_OFS)
      rd_mux = ctrl_q;
    else if (address == `FBCFG_OFS)
      rd_mux = cfg_q;
    else if (address == `STATUS_OFS)
    begin
      rd_mux[`ST_READY_LSB +: `NCH] = core_ready_q;
      rd_mux[`ST_START_LSB +: `NCH] = start_q;
      rd_mux[`ST_EXT_RDY]           = ext_ready_q;
      rd_mux[`ST_TRIG_SEEN]         = seen_q;
      rd_mux[`ST_BUSY]              = pend_q | wait_trig_q;
    end
    else if (address == `FBVAL_OFS)
      rd_mux = fbval_q;
    else if (is_ureg)
      rd_mux = ureg_q[ur_idx];
  end
  // pins pass two flops first; trigger age saturates; upstream ready, rearm
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      trig_s_q     <= 2'b00;
      trig_d_q     <= 1'b0;
      ld_s1_q      <= {`FB_W{1'b0}};
      ld_s2_q      <= {`FB_W{1'b0}};
      rel_s_q      <= 2'b00;
      age_q        <= {`AGE_W{1'b0}};
      seen_q       <= 1'b0;
      ext_ready_q  <= 1'b0;
      trig_rearm_q <= 1'b0;
    end
    else if (ce)
    begin
      trig_s_q <= {trig_s_q[0], link_trig};
      trig_d_q <= trig_s_q[1];
      ld_s1_q  <= link_data;
      ld_s2_q  <= ld_s1_q;
      rel_s_q  <= {rel_s_q[0], ext_release};
      if (trig_edge)
      begin
        age_q  <= {`AGE_W{1'b0}};
        seen_q <= 1'b1;
      end
      else if (~&age_q)
        age_q <= age_q + 1'b1;
      ext_ready_q  <= src_ext & any_wait & all_local;
      // restart count and holdoff so each check sees the same pattern
      trig_rearm_q <= trig_en & release_now;
    end
  end
  // avalon slave: one wait cycle, then a single-cycle answer
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      ctrl_q      <= `CTRL_RST;
    end
    else if (ce)
    begin
      if (bus_req && waitrequest)
      begin
        waitrequest <= 1'b0;
        readdata    <= rd_mux;
      end
      else
        waitrequest <= 1'b1;
      // channel enables and source select steer the barrier
      if (bus_hit && write && address == `CTRL_OFS)
        ctrl_q <= (ctrl_q & ~lane_m) | (writedata & lane_m);
    end
  end
  // sequencer operations; the core stalls while a sample is pending
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      instr_ready_q  <= 1'b1;
      result_valid_q <= 1'b0;
      result_q       <= 32'h0000_0000;
      table_play_q   <= 1'b0;
      table_index_q  <= {`FB_W{1'b0}};
      cfg_q          <= `CFG_RST;
      fbval_q        <= 32'h0000_0000;
      pend_q         <= 1'b0;
      pend_play_q    <= 1'b0;
      pend_raw_q     <= 1'b0;
      wait_trig_q    <= 1'b0;
      dly_q          <= {`AGE_W{1'b0}};
      for (i = 0; i < 4; i = i + 1)
        ureg_q[i] <= 32'h0000_0000;
    end
    else if (ce)
    begin
      result_valid_q <= 1'b0;
      table_play_q   <= 1'b0;
      if (bus_hit && write && is_ureg)
        ureg_q[ur_idx] <= (ureg_q[ur_idx] & ~lane_m) | (writedata & lane_m);
      if (take)
      begin
        case (instr_op)
          `OP_FB_CFG:
            cfg_q <= instr_arg | (32'h1 << `CFG_SET_BIT);
          `OP_WAIT_TRIG:
          begin
            // a fresh trigger is required; the stale one is forgotten
            wait_trig_q   <= 1'b1;
            instr_ready_q <= 1'b0;
          end
          `OP_READ_FB, `OP_PLAY:
          begin
            pend_q        <= 1'b1;
            pend_play_q   <= (instr_op == `OP_PLAY);
            pend_raw_q    <= instr_raw;
            dly_q         <= instr_arg[`AGE_W-1:0];
            instr_ready_q <= 1'b0;
          end
          `OP_UREG:
            ureg_q[instr_arg[1:0]] <= instr_var;
          default:
            instr_ready_q <= 1'b1;
        endcase
      end
      else if (wait_trig_q && trig_edge)
      begin
        wait_trig_q   <= 1'b0;
        instr_ready_q <= 1'b1;
      end
      else if (due)
      begin
        pend_q        <= 1'b0;
        instr_ready_q <= 1'b1;
        fbval_q        <= {{(32-`FB_W){1'b0}}, fb_pick};
        table_play_q   <= pend_play_q;
        result_valid_q <= ~pend_play_q;
        if (pend_play_q)
          table_index_q <= fb_pick;
        else
          result_q <= {{(32-`FB_W){1'b0}}, fb_pick};
      end
    end
  end
  // per-channel run sequence: prefetch, barrier, execute
  genvar k;
  generate
    for (k = 0; k < `NCH; k = k + 1)
    begin : g_ch
      reg [1:0] st_q; // channel state
      always @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          st_q            <= CH_IDLE;
          pf_req_q[k]     <= 1'b0;
          core_ready_q[k] <= 1'b0;
          start_q[k]      <= 1'b0;
        end
        else if (ce)
        begin
          case (st_q)
            CH_IDLE:
            begin
              if (run_req[k])
              begin
                st_q        <= CH_PF;
                pf_req_q[k] <= 1'b1;
              end
            end
            CH_PF:
            begin
              if (pf_done[k])
              begin
                pf_req_q[k] <= 1'b0;
                if (chen[k])
                begin
                  st_q            <= CH_SYNC;
                  core_ready_q[k] <= 1'b1;
                end
                else
                begin
                  st_q       <= CH_RUN;
                  start_q[k] <= 1'b1;
                end
              end
            end
            CH_SYNC:
            begin
              if (release_now)
              begin
                st_q            <= CH_RUN;
                core_ready_q[k] <= 1'b0;
                start_q[k]      <= 1'b1;
              end
            end
            CH_RUN:
            begin
              if (!run_req[k])
              begin
                st_q       <= CH_IDLE;
                start_q[k] <= 1'b0;
              end
            end
            default:
              st_q <= CH_IDLE;
          endcase
        end
      end
    end
  endgenerate
endmodule // feedback_and_start_sync
`default_nettype wire

// File: bench/feedback_and_start_sync_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sync_chk (
  input wire logic       core_clk,       // sequencer clock
  input wire logic       rst,            // async reset
  input wire logic       read,           // bus read
  input wire logic       write,          // bus write
  input wire logic       waitrequest,    // bus stall
  input wire logic       result_valid_q, // feedback result pulse
  input wire logic [3:0] run_req,        // run request
  input wire logic [3:0] pf_done,        // prefetch done
  input wire logic [3:0] pf_req_q,       // prefetch request
  input wire logic [3:0] core_ready_q,   // cores at the barrier
  input wire logic [3:0] start_q,        // cores running
  input wire logic       trig_ready,     // trigger unit ready
  input wire logic       trig_rearm_q    // trigger unit restart
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // a run request fetches the program on the next edge
  pf_start_a: assert property ($rose(run_req[0]) |=> pf_req_q[0])
    else $error("prefetch not requested");
  // a core only reports ready once its prefetch is done
  ready_after_pf_a: assert property ($rose(core_ready_q[0]) |-> $past(pf_done[0]))
    else $error("ready before prefetch done");
  // release frees every waiting core at the same edge
  joint_release_a: assert property ($fell(core_ready_q[0]) && run_req[0]
    |-> start_q[0] && core_ready_q == 4'h0)
    else $error("release not joint");
  // a core that skips the barrier starts straight after prefetch
  bypass_start_a: assert property ($rose(start_q[2]) && !$past(core_ready_q[2])
    |-> $past(pf_done[2]))
    else $error("bypass start without prefetch");
  // the trigger unit is only restarted once it was ready
  rearm_gate_a: assert property (trig_rearm_q
    |-> $past(trig_ready) && $past(core_ready_q) != 4'h0)
    else $error("trigger restart without barrier");
  // one restart per check keeps trigger counts equal
  rearm_pulse_a: assert property (trig_rearm_q |=> !trig_rearm_q)
    else $error("trigger restart longer than a cycle");
  // a feedback result is handed over once
  result_pulse_a: assert property (result_valid_q |=> !result_valid_q)
    else $error("result pulse too long");
  // a bus request is answered after one edge
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  // the answer stands for a single cycle
  bus_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer too long");
endmodule // sync_chk
bind feedback_and_start_sync sync_chk sync_chk_i (.core_clk(core_clk), .rst(rst), .read(read),
  .write(write), .waitrequest(waitrequest), .result_valid_q(result_valid_q),
  .run_req(run_req), .pf_done(pf_done), .pf_req_q(pf_req_q), .core_ready_q(core_ready_q),
  .start_q(start_q), .trig_ready(trig_ready), .trig_rearm_q(trig_rearm_q));
`default_nettype wire

// File: bench/sync_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sync_partner (
  input wire logic       core_clk,    // sequencer clock
  input wire logic       rst,         // async reset
  input wire logic [3:0] pf_req_q,    // prefetch request
  input wire logic       ext_ready_q, // instrument ready
  input wire logic       trig_hold,   // trigger unit busy
  input wire logic       peer_ok,     // other instruments ready
  output logic     [3:0] pf_done,     // prefetch done
  output logic           trig_ready,  // trigger unit ready
  output logic           ext_release  // controller release
);
  logic [3:0] pf_busy_q; // copy in flight
  // memory copy takes two cycles, so the barrier never sees it at once
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pf_busy_q   <= 4'h0;
      pf_done     <= 4'h0;
      trig_ready  <= 1'b0;
      ext_release <= 1'b0;
    end
    else
    begin
      pf_busy_q   <= pf_req_q;
      pf_done     <= pf_busy_q & pf_req_q; // program, table, waves copied
      trig_ready  <= !trig_hold;
      ext_release <= ext_ready_q & peer_ok; // held until all report
    end
  end
endmodule // sync_partner
`default_nettype wire

// File: bench/feedback_and_start_sync_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "feedback_sync_regs.vh"
module feedback_and_start_sync_test;
  logic        core_clk, rst, read, write, waitrequest, trig_hold, peer_ok;
  logic        instr_valid, instr_raw, instr_ready_q, result_valid_q, table_play_q;
  logic        link_trig, trig_ready, trig_rearm_q, ext_release, ext_ready_q;
  logic [5:0]  address;
  logic [3:0]  byteenable, run_req, pf_done, pf_req_q, core_ready_q, start_q;
  logic [2:0]  instr_op;
  logic [15:0] link_data, int_fb_data, table_index_q;
  logic [31:0] writedata, readdata, instr_arg, instr_var, result_q, rd;
  integer      errors, checked, lat;
  // clock enable tied on: freezing is not exercised here
  feedback_and_start_sync feedback_and_start_sync_i (.core_clk, .rst, .ce(1'b1), .address,
    .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .instr_valid, .instr_op,
    .instr_raw, .instr_arg, .instr_var, .instr_ready_q, .result_valid_q, .result_q,
    .table_play_q, .table_index_q, .link_trig, .link_data, .int_fb_data, .run_req, .pf_done,
    .pf_req_q, .core_ready_q, .start_q, .trig_ready, .trig_rearm_q, .ext_release, .ext_ready_q);
  sync_partner sync_partner_i (.core_clk, .rst, .pf_req_q, .ext_ready_q, .trig_hold, .peer_ok,
    .pf_done, .trig_ready, .ext_release);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  // one bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
  begin
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    @(posedge core_clk);
    while (waitrequest !== 1'b0)
      @(posedge core_clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  end
  endtask
  // offer an op; for reads and plays wait for the answer pulse
  task automatic op(input logic [2:0] o, input logic r, input logic [31:0] a, v);
  begin
    instr_op <= o;
    instr_raw <= r;
    instr_arg <= a;
    instr_var <= v;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    while (instr_ready_q !== 1'b1)
      @(posedge core_clk);
    instr_valid <= 1'b0;
    lat = 0;
    if (o == `OP_READ_FB || o == `OP_PLAY)
      while (result_valid_q !== 1'b1 && table_play_q !== 1'b1 && lat < 100)
      begin
        @(posedge core_clk);
        lat = lat + 1;
      end
    // an answer that never comes counts against the run
    if (lat >= 100)
    begin
      errors = errors + 1;
      $display("MISMATCH op answer expected pulse seen none");
    end
  end
  endtask
  task automatic trig;
  begin
    link_trig <= 1'b1;
    repeat (4) @(posedge core_clk);
    link_trig <= 1'b0;
    repeat (4) @(posedge core_clk);
  end
  endtask
  task automatic end_sim;
  begin
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // cut a hang well after the roughly 130 cycles the run needs
  initial
  begin
    #125000;
    errors = errors + 1;
    end_sim;
  end
  initial
  begin
    {rst, read, write, instr_valid, instr_raw, link_trig, trig_hold, peer_ok} = 8'h80;
    {address, instr_op, run_req, link_data, int_fb_data} = 45'h0;
    {writedata, instr_arg, instr_var} = 96'h0;
    byteenable = 4'hf;
    errors = 0;
    checked = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(0, `CTRL_OFS, 0);
    chk("ctrl", `CTRL_RST, rd);
    bus(0, `FBCFG_OFS, 0);
    chk("fbcfg reset", `CFG_RST, rd);
    bus(0, 6'h20, 0);
    chk("unmapped", 32'h0, rd);
    bus(1, `UREG_LAST, 32'h1234_5678);
    bus(0, `UREG_LAST, 0);
    chk("ureg3", 32'h1234_5678, rd);
    // trigger and read together: the answer must wait out the delay
    link_data <= 16'hb5a3;
    link_trig <= 1'b1;
    op(`OP_READ_FB, 0, 32'd20, 0);
    link_trig <= 1'b0;
    chk("fb plain", 32'h0000_b5a3, result_q);
    chk("fb delay", 32'h1, 32'(lat >= 20 && lat <= 30));
    bus(0, `FBVAL_OFS, 0);
    chk("fbval", 32'h0000_b5a3, rd);
    // index 4, size 3, offset 2 turns b5a3 into 2 + 2
    op(`OP_FB_CFG, 0, 32'h0002_0034, 0);
    bus(0, `FBCFG_OFS, 0);
    chk("fbcfg", 32'h0002_0234, rd);
    op(`OP_READ_FB, 0, 32'd5, 0);
    chk("fb processed", 32'h4, result_q);
    op(`OP_READ_FB, 1, 32'd5, 0);
    chk("fb raw", 32'h0000_b5a3, result_q);
    op(`OP_PLAY, 0, 32'd5, 0);
    chk("table index", 32'h4, 32'(table_index_q));
    // internal path, gated by a wait for the link trigger
    bus(1, `CTRL_OFS, 32'h4);
    int_fb_data <= 16'h0c3c;
    op(`OP_WAIT_TRIG, 0, 0, 0);
    repeat (2) @(posedge core_clk);
    chk("wait stall", 32'h0, 32'(instr_ready_q));
    trig;
    op(`OP_READ_FB, 1, 32'd5, 0);
    chk("fb internal", 32'h0000_0c3c, result_q);
    op(`OP_UREG, 0, 0, result_q);
    bus(0, `UREG_OFS, 0);
    chk("ureg0", 32'h0000_0c3c, rd);
    // cores 0 and 1 plus the trigger unit at the barrier, trigger unit late
    bus(1, `CTRL_OFS, 32'h32);
    trig_hold <= 1'b1;
    run_req <= 4'hf;
    repeat (8) @(posedge core_clk);
    chk("start early", 32'hc, 32'(start_q));
    chk("waiting", 32'h3, 32'(core_ready_q));
    chk("ext idle", 32'h0, 32'(ext_ready_q));
    bus(0, `STATUS_OFS, 0);
    chk("status wait", 32'h0002_0c03, rd);
    trig_hold <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("start all", 32'hf, 32'(start_q));
    run_req <= 4'h0;
    repeat (4) @(posedge core_clk);
    // external source: the controller holds release for a peer
    bus(1, `CTRL_OFS, 32'h11);
    run_req <= 4'h1;
    repeat (10) @(posedge core_clk);
    chk("ext ready", 32'h1, 32'(ext_ready_q));
    chk("ext stall", 32'h0, 32'(start_q));
    peer_ok <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("ext start", 32'h1, 32'(start_q));
    run_req <= 4'h0;
    repeat (4) @(posedge core_clk);
    end_sim;
  end
endmodule // feedback_and_start_sync_test
`default_nettype wire
